// ### core/usc_line_drive.sv
/*
 serial side drive: rts_n, sout, infrared break pulse and loopback.
 assumes control bits and the transmit line arrive on clk_sys.
*/
`default_nettype none

module usc_line_drive (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control from the register file
    input wire usc_pkg::usc_ctl_s ctl,
    input wire logic rx_hit,
    // transmit datapath
    input wire logic tx_serial,
    input wire logic sir_enc_n,
    // pins and internal loop
    output logic rts_n,
    output logic sout,
    output logic sir_out_n,
    output logic loop_rts,
    output logic loop_rx_line
);
    usc_pkg::usc_drv_s q;
    usc_pkg::usc_drv_s n;
    logic sir_brk;
    logic rts_on;

    assign sir_brk = ctl.brk & ctl.sir & ~ctl.loop;
    // auto flow only gates when the queues exist
    assign rts_on = ctl.rts & ~(ctl.afc & ctl.qen & rx_hit); // R04

    always_comb begin
        n = q;
        if (sir_brk) begin
            if (q.sir_cnt == usc_pkg::SIR_PER_M1) begin
                n.sir_cnt = 4'h0;
            end else begin
                n.sir_cnt = q.sir_cnt + 4'h1;
            end
        end else begin
            n.sir_cnt = 4'h0;
        end
        n.rts_n = ctl.loop | ~rts_on; // R02 R03 R05
        n.loop_rts = ctl.loop & ctl.rts; // R05
        // pins idle at mark while looped back
        n.sout = ctl.loop | (~ctl.brk & tx_serial); // R06
        n.loop_rx = ~ctl.loop | (~ctl.brk & tx_serial); // R08
        if (sir_brk) begin
            n.sir_n = q.sir_cnt >= usc_pkg::SIR_LOW; // R07
        end else begin
            n.sir_n = ctl.loop | sir_enc_n;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= usc_pkg::DRV_RST;
        end else begin
            q <= n;
        end
    end

    assign rts_n = q.rts_n;
    assign sout = q.sout;
    assign sir_out_n = q.sir_n;
    assign loop_rts = q.loop_rts;
    assign loop_rx_line = q.loop_rx;
endmodule // usc_line_drive

`default_nettype wire

// ### core/usc_pkg.sv
/*
 constants, carriers and helpers of the shadow control bit block.
 assumes a 32-bit avalon-mm register bus with byte addresses.
*/
`default_nettype none

package usc_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_QCTL = 32'h5000_1108;
    localparam logic [31:0] ADDR_LCTL = 32'h5000_110c;
    localparam logic [31:0] ADDR_MCTL = 32'h5000_1110;
    localparam logic [31:0] ADDR_SRTS = 32'h5000_118c;
    localparam logic [31:0] ADDR_SBRK = 32'h5000_1190;
    localparam logic [31:0] ADDR_SDMA = 32'h5000_1194;
    localparam logic [31:0] ADDR_SQEN = 32'h5000_1198;

    // field positions
    localparam int unsigned MCR_RTS = 1;
    localparam int unsigned MCR_LOOP = 4;
    localparam int unsigned MCR_AFC = 5;
    localparam int unsigned MCR_SIR = 6;
    localparam int unsigned LCR_BRK = 6;
    localparam int unsigned QCR_EN = 0;
    localparam int unsigned QCR_DMA = 3;
    localparam int unsigned QCR_RXT = 6;
    localparam int unsigned SHADOW_BIT = 0;

    // implemented bits and reset values
    localparam logic [15:0] MCR_MASK = 16'h0072;
    localparam logic [15:0] LCR_MASK = 16'h00ff;
    localparam logic [15:0] QCR_MASK = 16'h00f9;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // receive queue levels
    localparam logic [4:0] RXQ_DEPTH = 5'h10;
    localparam logic [4:0] LVL_EMPTY = 5'h00;
    localparam logic [4:0] TRIG_ONE = 5'h01;
    localparam logic [4:0] TRIG_QTR = RXQ_DEPTH >> 2;
    localparam logic [4:0] TRIG_HALF = RXQ_DEPTH >> 1;
    localparam logic [4:0] TRIG_FULL2 = RXQ_DEPTH - 5'h02;

    // infrared break pulse, in clk_sys cycles
    localparam logic [3:0] SIR_PER_M1 = 4'hf;
    localparam logic [3:0] SIR_LOW = 4'h3;
    localparam logic [4:0] RUN_MAX = 5'h1f;

    typedef struct packed {
        logic rts;
        logic loop;
        logic afc;
        logic sir;
        logic brk;
        logic qen;
        logic dma;
        logic [1:0] rxt;
    } usc_ctl_s;

    typedef struct packed {
        logic [15:0] modem_control_register;
        logic [15:0] line_control_register;
        logic [15:0] qcr;
        logic [31:0] rdata;
        logic waitrequest;
        logic txq_rst;
        logic rxq_rst;
        logic dtx_n;
        logic drx_n;
        logic [4:0] brk_run;
    } usc_regs_s;

    typedef struct packed {
        logic rts_n;
        logic sout;
        logic sir_n;
        logic loop_rts;
        logic loop_rx;
        logic [3:0] sir_cnt;
    } usc_drv_s;

    localparam usc_regs_s REGS_RST = '{modem_control_register: REG_RST, line_control_register: REG_RST,
        qcr: REG_RST, rdata: RD_ZERO, waitrequest: 1'h1, txq_rst: 1'h0,
        rxq_rst: 1'h0, dtx_n: 1'h1, drx_n: 1'h1, brk_run: 5'h00};

    localparam usc_drv_s DRV_RST = '{rts_n: 1'h1, sout: 1'h1,
        sir_n: 1'h1, loop_rts: 1'h0, loop_rx: 1'h1, sir_cnt: 4'h0};

    function automatic logic [4:0] usc_trig_level(input logic [1:0] code);
        case (code)
            2'h0: usc_trig_level = TRIG_ONE;
            2'h1: usc_trig_level = TRIG_QTR;
            2'h2: usc_trig_level = TRIG_HALF;
            default: usc_trig_level = TRIG_FULL2;
        endcase
    endfunction
endpackage

`default_nettype wire

// ### core/usc_shadow_ctl.sv
/*
 shadow control bit block: modem, line and queue control registers,
 their single-bit shadows, dma request mode and queue reset.
 assumes an avalon-mm master on clk_sys and queue levels on clk_sys.
*/
// Implementation choice: the Avalon-MM interface to the registers.
`default_nettype none

// Function
// R01 - each shadow bit and its control register bit are one flop.
// R02 - the active-low rts pin follows the rts control bit.
// R03 - without auto flow control a set rts bit drives rts_n low.
// R04 - with auto flow and queues on, rts_n goes high at the rx trigger.
// R05 - loopback holds rts_n high and routes rts to the internal input.
// R06 - break outside loopback holds sout low until break is cleared.
// R07 - break in infrared mode pulses sir_out_n continuously.
// R08 - break in loopback goes to the internal receive line only.
// R09 - the dma mode bit picks mode 0 or mode 1 request signalling.
// R10 - the queue enable bit turns both queues on or off together.
// R11 - clearing queue enable resets both queue controllers to empty.
// R12 - all four shadow bits reset to zero and sit in bit 0.
// R13 - rx trigger code picks 1, quarter, half or two less than full.
// R14 - reserved shadow bits read zero and ignore writes.
module usc_shadow_ctl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // queue datapath
    input wire logic tx_empty,
    input wire logic tx_full,
    input wire logic [4:0] rx_level,
    output logic queue_enable,
    output logic tx_queue_reset,
    output logic rx_queue_reset,
    output logic dma_tx_req_n,
    output logic dma_rx_req_n,
    // serial side
    input wire logic tx_serial,
    input wire logic sir_enc_n,
    output logic rts_n,
    output logic sout,
    output logic sir_out_n,
    output logic loop_rts,
    output logic loop_rx_line
);
    usc_pkg::usc_regs_s q;
    usc_pkg::usc_regs_s n;
    usc_pkg::usc_ctl_s ctl;
    logic req;
    logic accept;
    logic wr;
    logic rx_hit;

    assign req = read | write;
    // one wait cycle per access keeps read data registered
    assign accept = req & ~q.waitrequest;
    // all implemented bits live in byte lane 0
    assign wr = accept & write & byteenable[0];

    // one flop per control bit, shared by both views
    assign ctl.rts = q.modem_control_register[usc_pkg::MCR_RTS]; // R01
    assign ctl.loop = q.modem_control_register[usc_pkg::MCR_LOOP];
    assign ctl.afc = q.modem_control_register[usc_pkg::MCR_AFC];
    assign ctl.sir = q.modem_control_register[usc_pkg::MCR_SIR];
    assign ctl.brk = q.line_control_register[usc_pkg::LCR_BRK]; // R01
    assign ctl.qen = q.qcr[usc_pkg::QCR_EN]; // R10
    assign ctl.dma = q.qcr[usc_pkg::QCR_DMA];
    assign ctl.rxt = q.qcr[usc_pkg::QCR_RXT +: 2];

    assign rx_hit = rx_level >= usc_pkg::usc_trig_level(ctl.rxt); // R13

    always_comb begin
        logic [31:0] rv;
        rv = usc_pkg::RD_ZERO;
        n = q;
        n.txq_rst = 1'h0;
        n.rxq_rst = 1'h0;
        n.waitrequest = ~(req & q.waitrequest);

        // read data is prepared in the wait cycle
        case (address)
            usc_pkg::ADDR_MCTL: begin
                rv[15:0] = q.modem_control_register;
            end
            usc_pkg::ADDR_LCTL: begin
                rv[15:0] = q.line_control_register;
            end
            usc_pkg::ADDR_QCTL: begin
                rv[15:0] = q.qcr;
            end
            usc_pkg::ADDR_SRTS: begin
                rv[usc_pkg::SHADOW_BIT] = ctl.rts; // R01 R14
            end
            usc_pkg::ADDR_SBRK: begin
                rv[usc_pkg::SHADOW_BIT] = ctl.brk; // R01 R14
            end
            usc_pkg::ADDR_SDMA: begin
                rv[usc_pkg::SHADOW_BIT] = ctl.dma; // R01 R14
            end
            usc_pkg::ADDR_SQEN: begin
                rv[usc_pkg::SHADOW_BIT] = ctl.qen; // R01 R14
            end
            default: begin
                rv = usc_pkg::RD_ZERO;
            end
        endcase
        if (req && q.waitrequest) begin
            n.rdata = rv;
        end

        if (wr) begin
            case (address)
                usc_pkg::ADDR_MCTL: begin
                    n.modem_control_register = writedata[15:0] & usc_pkg::MCR_MASK;
                end
                usc_pkg::ADDR_LCTL: begin
                    n.line_control_register = writedata[15:0] & usc_pkg::LCR_MASK;
                end
                usc_pkg::ADDR_QCTL: begin
                    n.qcr = writedata[15:0] & usc_pkg::QCR_MASK;
                end
                usc_pkg::ADDR_SRTS: begin
                    n.modem_control_register[usc_pkg::MCR_RTS] = writedata[0]; // R01 R14
                end
                usc_pkg::ADDR_SBRK: begin
                    n.line_control_register[usc_pkg::LCR_BRK] = writedata[0]; // R01 R14
                end
                usc_pkg::ADDR_SDMA: begin
                    n.qcr[usc_pkg::QCR_DMA] = writedata[0]; // R01 R14
                end
                usc_pkg::ADDR_SQEN: begin
                    n.qcr[usc_pkg::QCR_EN] = writedata[0]; // R01 R14
                end
                default: begin
                end
            endcase
        end

        // falling enable empties both queues, whichever view wrote it
        if (q.qcr[usc_pkg::QCR_EN] && !n.qcr[usc_pkg::QCR_EN]) begin
            n.txq_rst = 1'h1; // R11
            n.rxq_rst = 1'h1; // R11
        end

        // mode 1 needs the queues; without them mode 0 applies
        if (ctl.dma && ctl.qen) begin
            n.dtx_n = tx_full; // R09
            n.drx_n = ~rx_hit; // R09
        end else begin
            n.dtx_n = ~tx_empty; // R09
            n.drx_n = rx_level == usc_pkg::LVL_EMPTY; // R09
        end

        // run length of an infrared break, only watched by checks
        if (ctl.brk && ctl.sir && !ctl.loop) begin
            if (q.brk_run != usc_pkg::RUN_MAX) begin
                n.brk_run = q.brk_run + 5'h01;
            end
        end else begin
            n.brk_run = 5'h00;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= usc_pkg::REGS_RST; // R12
        end else begin
            q <= n;
        end
    end

    assign readdata = q.rdata;
    assign waitrequest = q.waitrequest;
    assign queue_enable = q.qcr[usc_pkg::QCR_EN]; // R10
    assign tx_queue_reset = q.txq_rst;
    assign rx_queue_reset = q.rxq_rst;
    assign dma_tx_req_n = q.dtx_n;
    assign dma_rx_req_n = q.drx_n;

    usc_line_drive u_line (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctl(ctl),
        .rx_hit(rx_hit),
        .tx_serial(tx_serial),
        .sir_enc_n(sir_enc_n),
        .rts_n(rts_n),
        .sout(sout),
        .sir_out_n(sir_out_n),
        .loop_rts(loop_rts),
        .loop_rx_line(loop_rx_line)
    );

    bus_wait_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not pulse low once");

    shadow_rts_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SRTS
        |=> q.modem_control_register[usc_pkg::MCR_RTS] == $past(writedata[0]))
    else $error("rts shadow write lost");

    line_brk_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_LCTL
        |=> ctl.brk == $past(writedata[usc_pkg::LCR_BRK]))
    else $error("line control break write lost");

    shadow_read_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        accept && read && address == usc_pkg::ADDR_SBRK
        |-> readdata == {31'h0000_0000, ctl.brk})
    else $error("break shadow read mismatch");

    rts_off_a: assert property ( // R02
        @(posedge clk_sys) disable iff (rst)
        !ctl.rts |=> rts_n)
    else $error("rts_n low with rts clear");

    rts_low_a: assert property ( // R03
        @(posedge clk_sys) disable iff (rst)
        ctl.rts && !ctl.loop && !ctl.afc |=> !rts_n)
    else $error("rts_n not low with rts set");

    rts_gate_a: assert property ( // R04
        @(posedge clk_sys) disable iff (rst)
        ctl.afc && ctl.qen && rx_hit |=> rts_n)
    else $error("rts_n not gated at receive trigger");

    rts_loop_a: assert property ( // R05
        @(posedge clk_sys) disable iff (rst)
        ctl.loop |=> rts_n && loop_rts == $past(ctl.rts))
    else $error("loopback rts routing wrong");

    brk_hold_a: assert property ( // R06
        @(posedge clk_sys) disable iff (rst)
        (ctl.brk && !ctl.loop) [*2] |-> !sout)
    else $error("sout not held low in break");

    sir_pulse_a: assert property ( // R07
        @(posedge clk_sys) disable iff (rst)
        q.brk_run == 5'h14 |-> ##[0:16] (!sir_out_n || q.brk_run == 5'h00))
    else $error("no infrared break pulse");

    loop_brk_a: assert property ( // R08
        @(posedge clk_sys) disable iff (rst)
        ctl.loop && ctl.brk |=> !loop_rx_line && sout)
    else $error("loopback break not kept internal");

    dma_mode0_a: assert property ( // R09
        @(posedge clk_sys) disable iff (rst)
        !rst && !ctl.dma |=> dma_tx_req_n == !$past(tx_empty))
    else $error("dma mode 0 transmit request wrong");

    dma_mode1_a: assert property ( // R09
        @(posedge clk_sys) disable iff (rst)
        ctl.dma && ctl.qen
        |=> dma_tx_req_n == $past(tx_full) && dma_rx_req_n == !$past(rx_hit))
    else $error("dma mode 1 requests wrong");

    queue_on_a: assert property ( // R10
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SQEN
        |=> queue_enable == $past(writedata[0]))
    else $error("queue enable write lost");

    queue_reset_a: assert property ( // R11
        @(posedge clk_sys) disable iff (rst)
        tx_queue_reset == $fell(queue_enable)
        && rx_queue_reset == tx_queue_reset)
    else $error("queue reset pulse wrong");

    reset_zero_a: assert property ( // R12
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> !ctl.rts && !ctl.brk && !ctl.dma && !ctl.qen
        && waitrequest)
    else $error("control bits not zero after reset");

    trig_full_a: assert property ( // R13
        @(posedge clk_sys) disable iff (rst)
        ctl.rxt == 2'h3 && rx_level == usc_pkg::TRIG_FULL2
        && ctl.afc && ctl.qen |=> rts_n)
    else $error("two less than full trigger missed");

    trig_one_a: assert property ( // R13
        @(posedge clk_sys) disable iff (rst)
        ctl.rxt == 2'h0 && rx_level == usc_pkg::LVL_EMPTY
        && ctl.rts && !ctl.loop |=> !rts_n)
    else $error("one character trigger fired early");

    reserved_a: assert property ( // R14
        @(posedge clk_sys) disable iff (rst)
        accept && read && address == usc_pkg::ADDR_SDMA
        |-> readdata[31:1] == 31'h0000_0000)
    else $error("reserved shadow bits not zero");

    shadow_brk_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SBRK
        |=> ctl.brk == $past(writedata[0]))
    else $error("break shadow write lost");

    shadow_dma_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SDMA
        |=> ctl.dma == $past(writedata[0]))
    else $error("dma shadow write lost");

    qen_read_a: assert property ( // R01
        @(posedge clk_sys) disable iff (rst)
        accept && read && address == usc_pkg::ADDR_SQEN
        |-> readdata == {31'h0000_0000, ctl.qen})
    else $error("queue enable shadow read mismatch");

    brk_only_a: assert property ( // R14
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SBRK
        |=> q.modem_control_register == $past(q.modem_control_register) && q.qcr == $past(q.qcr))
    else $error("break shadow write reached other bits");

    shadow_clear_a: assert property ( // R11
        @(posedge clk_sys) disable iff (rst)
        wr && address == usc_pkg::ADDR_SQEN && !writedata[0] && queue_enable
        |=> tx_queue_reset && rx_queue_reset)
    else $error("shadow enable clear kept the queues");

    rx_mode0_a: assert property ( // R09
        @(posedge clk_sys) disable iff (rst)
        !rst && !ctl.dma
        |=> dma_rx_req_n == ($past(rx_level) == usc_pkg::LVL_EMPTY))
    else $error("dma mode 0 receive request wrong");

    sout_pass_a: assert property ( // R06
        @(posedge clk_sys) disable iff (rst)
        !rst && !ctl.brk && !ctl.loop
        |=> sout == $past(tx_serial))
    else $error("sout not following transmit data");
endmodule // usc_shadow_ctl

`default_nettype wire

// ### verification/tb_top.sv
/*
 self-checking bench of the shadow control bit block.
 assumes a 125 MHz clk_sys and one avalon access at a time.
*/
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst, read, write, tx_empty, tx_full, tx_serial;
    logic sir_enc_n, waitrequest, queue_enable, tx_queue_reset;
    logic rx_queue_reset, dma_tx_req_n, dma_rx_req_n, rts_n, sout;
    logic sir_out_n, loop_rts, loop_rx_line, peer_ready;
    logic [31:0] address, writedata, readdata, rd, seed_val;
    logic [3:0] byteenable;
    logic [4:0] rx_level;
    logic [15:0] sout_lows, sir_lows, s0;
    int num_errors, num_checks, cycles;
    logic [31:0] sh_a [4] = '{usc_pkg::ADDR_SRTS, usc_pkg::ADDR_SBRK,
        usc_pkg::ADDR_SDMA, usc_pkg::ADDR_SQEN};
    logic [31:0] mn_a [4] = '{usc_pkg::ADDR_MCTL, usc_pkg::ADDR_LCTL,
        usc_pkg::ADDR_QCTL, usc_pkg::ADDR_QCTL};
    int pos_a [4] = '{1, 6, 3, 0};

    usc_shadow_ctl dut (.clk_sys(clk_sys), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .tx_empty(tx_empty), .tx_full(tx_full),
        .rx_level(rx_level), .queue_enable(queue_enable),
        .tx_queue_reset(tx_queue_reset), .rx_queue_reset(rx_queue_reset),
        .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n),
        .tx_serial(tx_serial), .sir_enc_n(sir_enc_n), .rts_n(rts_n),
        .sout(sout), .sir_out_n(sir_out_n), .loop_rts(loop_rts),
        .loop_rx_line(loop_rx_line));

    usc_modem_model modem (.clk_sys(clk_sys), .rst(rst), .rts_n(rts_n),
        .sout(sout), .sir_out_n(sir_out_n), .sout_lows(sout_lows),
        .sir_lows(sir_lows), .peer_ready(peer_ready));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // random line traffic; also the hang limit
    always @(posedge clk_sys) begin
        tx_serial <= 1'($urandom);
        sir_enc_n <= 1'($urandom);
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // expected receive threshold per trigger code
    function automatic logic [4:0] trig(input logic [1:0] c);
        case (c)
            2'h0: trig = 5'h01;
            2'h1: trig = 5'h04;
            2'h2: trig = 5'h08;
            default: trig = 5'h0e;
        endcase
    endfunction

    // request held until waitrequest is seen low at an edge
    task automatic bus_acc(input logic wr, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk_sys);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        bus_acc(1'b1, a, d, 4'h1);
    endtask

    task automatic bus_rd(input logic [31:0] a);
        bus_acc(1'b0, a, 32'h0000_0000, 4'h0);
    endtask

    task automatic t_reset;
        int i;
        for (i = 0; i < 4; i++) begin
            bus_rd(sh_a[i]);
            chk(rd, 32'h0000_0000);
        end
        bus_wr(32'h5000_11a0, $urandom);
        bus_rd(32'h5000_11a0);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_mirror;
        int i;
        logic [31:0] d;
        for (i = 0; i < 4; i++) begin
            d = $urandom | 32'h0000_0001;
            bus_acc(1'b1, sh_a[i], d, 4'he);
            bus_rd(sh_a[i]);
            chk(rd, 32'h0000_0000);
            bus_wr(sh_a[i], d);
            bus_rd(sh_a[i]);
            chk(rd, 32'h0000_0001);
            bus_rd(mn_a[i]);
            chk(rd & (32'h0000_0001 << pos_a[i]), 32'h1 << pos_a[i]);
            bus_wr(mn_a[i], 32'h0000_0000);
            bus_rd(sh_a[i]);
            chk(rd, 32'h0000_0000);
        end
        $display("test mirror done");
    endtask

    task automatic t_queue;
        bus_wr(usc_pkg::ADDR_SQEN, 32'h0000_0001);
        tick(1);
        chk1(queue_enable, 1'b1);
        bus_wr(usc_pkg::ADDR_QCTL, 32'h0000_0000);
        tick(1);
        chk1(tx_queue_reset, 1'b1);
        chk1(rx_queue_reset, 1'b1);
        chk1(queue_enable, 1'b0);
        tick(1);
        chk1(tx_queue_reset, 1'b0);
        bus_wr(usc_pkg::ADDR_QCTL, 32'h0000_0001);
        bus_wr(usc_pkg::ADDR_SQEN, 32'h0000_0000);
        tick(1);
        chk1(rx_queue_reset, 1'b1);
        $display("test queue done");
    endtask

    task automatic t_rts;
        int c, k;
        logic [4:0] t, lvl;
        for (c = 0; c < 4; c++) begin
            t = trig(2'(c));
            bus_wr(usc_pkg::ADDR_QCTL, {24'h00_0000, 2'(c), 6'h01});
            bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0022);
            for (k = 0; k < 3; k++) begin
                lvl = (k == 2) ? 5'($urandom_range(16)) : t - 5'h01 + 5'(k);
                @(posedge clk_sys);
                rx_level <= lvl;
                tick(2);
                chk1(rts_n, lvl >= t);
            end
        end
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0002);
        tick(2);
        chk1(rts_n, 1'b0);
        bus_wr(usc_pkg::ADDR_SRTS, 32'h0000_0000);
        tick(2);
        chk1(rts_n, 1'b1);
        chk1(peer_ready, 1'b0);
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0012);
        tick(2);
        chk1(rts_n, 1'b1);
        chk1(loop_rts, 1'b1);
        bus_wr(usc_pkg::ADDR_SRTS, 32'h0000_0000);
        tick(2);
        chk1(loop_rts, 1'b0);
        $display("test rts done");
    endtask

    task automatic t_brk;
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0000);
        bus_wr(usc_pkg::ADDR_SBRK, 32'h0000_0001);
        tick(2);
        s0 = sout_lows;
        tick(40);
        chk({16'h0000, sout_lows - s0}, 32'h0000_0028);
        chk1(loop_rx_line, 1'b1);
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0040);
        tick(2);
        s0 = sir_lows;
        tick(64);
        chk({16'h0000, sir_lows - s0}, 32'h0000_000c);
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0010);
        tick(2);
        chk1(sout, 1'b1);
        chk1(loop_rx_line, 1'b0);
        bus_wr(usc_pkg::ADDR_MCTL, 32'h0000_0000);
        bus_wr(usc_pkg::ADDR_LCTL, 32'h0000_0000);
        tick(2);
        s0 = sout_lows;
        tick(40);
        chk1(16'(sout_lows - s0) < 16'h0028, 1'b1);
        $display("test break done");
    endtask

    task automatic t_dma;
        int m, k;
        logic [1:0] c;
        logic [4:0] lvl;
        logic te, tf;
        for (m = 0; m < 3; m++) begin
            for (k = 0; k < 4; k++) begin
                c = 2'($urandom);
                bus_wr(usc_pkg::ADDR_QCTL, {24'h00_0000, c, 2'h0,
                    m > 0, 2'h0, m == 2});
                lvl = (k == 0) ? trig(c) : (k == 1) ? 5'h00
                    : 5'($urandom_range(16));
                te = 1'($urandom);
                tf = 1'($urandom);
                @(posedge clk_sys);
                rx_level <= lvl;
                tx_empty <= te;
                tx_full <= tf;
                tick(2);
                if (m == 2) begin
                    chk1(dma_tx_req_n, tf);
                    chk1(dma_rx_req_n, !(lvl >= trig(c)));
                end else begin
                    chk1(dma_tx_req_n, !te);
                    chk1(dma_rx_req_n, lvl == 5'h00);
                end
            end
        end
        $display("test dma done");
    endtask

    initial begin
        seed_val = $urandom(21);
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 32'h0000_0000;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        tx_empty = 1'b1;
        tx_full = 1'b0;
        rx_level = 5'h00;
        repeat (8) @(posedge clk_sys);
        chk1(waitrequest, 1'b1);
        chk1(rts_n, 1'b1);
        rst <= 1'b0;
        t_reset();
        t_mirror();
        t_queue();
        t_rts();
        t_brk();
        t_dma();
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire

// ### verification/usc_modem_model.sv
/*
 modem side model: watches the serial pins and counts line activity.
 assumes pins are registered on clk_sys; counters wrap at 16 bits.
*/
`default_nettype none

module usc_modem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial pins from the port
    input wire logic rts_n,
    input wire logic sout,
    input wire logic sir_out_n,
    // observed activity
    output logic [15:0] sout_lows,
    output logic [15:0] sir_lows,
    output logic peer_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // a modem only sees the level, so rts_n is taken as it stands
    assign peer_ready = !rts_n;

    // spacing cycles; a held break and a pulsed one differ here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sout_lows <= 16'h0000;
            sir_lows <= 16'h0000;
        end else begin
            sout_lows <= sout_lows + {15'h0000, !sout};
            sir_lows <= sir_lows + {15'h0000, !sir_out_n};
        end
    end
endmodule // usc_modem_model

`default_nettype wire
